// ==== tlih_top.sv ====
// two-level interrupt handler: pending flags, enables, priority resolve, vector request
// assumes: register port and core handshake on sys_clk; port pins asynchronous
module tlih_top
  import tlih_pkg::*;
#(
  parameter logic [15:0] AUTO_CLR_MASK = 16'h0000,
  parameter int PIN_N = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] src_event,
  input wire logic [PIN_N-1:0] port_pins,
  input wire logic instr_done,
  input wire logic irq_ack,
  input wire logic return_from_interrupt_done,
  output logic irq_req,
  output logic irq_high,
  output logic [3:0] irq_src,
  output logic [15:0] irq_vector
);

  localparam tlih_mask_t EXT_MASK = tlih_mask_t'((16'h0001 << `TLIH_EXT_A_IDX) | (16'h0001 << `TLIH_EXT_B_IDX));

  // valid bit on top, index of the lowest set bit below
  function automatic logic [4:0] lowest_set(input tlih_mask_t v);
    lowest_set = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        lowest_set = {1'b1, 4'(i)};
      end
    end
  endfunction

  tlih_mask_t en_r;
  logic glb_r;
  tlih_mask_t prio_r;
  tlih_mask_t pend_int_r;
  tlih_mask_t pend_int_nxt;
  logic [7:0] pin_cfg_r;
  logic [1:0] sense_r;
  logic lo_act_r;
  logic hi_act_r;
  logic hold_r;
  logic hold_nxt;
  logic irq_req_r;
  logic irq_high_r;
  tlih_src_t irq_src_r;
  tlih_word_t irq_vector_r;
  tlih_word_t rdata_r;
  tlih_word_t rdata_nxt;
  tlih_level_e level_w;

  logic wr_enable_w;
  logic wr_global_w;
  logic wr_prio_w;
  logic wr_set_w;
  logic wr_clr_w;
  logic wr_pin_w;
  logic wr_sense_w;
  tlih_mask_t sw_set_w;
  tlih_mask_t sw_clr_w;
  tlih_mask_t ack_mask_w;
  logic [1:0] ext_pend_w;
  tlih_mask_t pend_w;
  tlih_mask_t eligible_w;
  tlih_mask_t hi_cand_w;
  tlih_mask_t lo_cand_w;
  logic [4:0] hi_pick_w;
  logic [4:0] lo_pick_w;
  logic hi_ok_w;
  logic lo_ok_w;
  logic req_ok_w;
  tlih_src_t src_nxt_w;
  tlih_word_t vec_nxt_w;

  ////////////////////////////////////////////////////////////////////////////
  // register port decode
  assign wr_enable_w = reg_wr && (reg_addr == `TLIH_ADDR_ENABLE);
  assign wr_global_w = reg_wr && (reg_addr == `TLIH_ADDR_GLOBAL);
  assign wr_prio_w = reg_wr && (reg_addr == `TLIH_ADDR_PRIORITY);
  assign wr_set_w = reg_wr && (reg_addr == `TLIH_ADDR_PEND_SET);
  assign wr_clr_w = reg_wr && (reg_addr == `TLIH_ADDR_PEND_CLR);
  assign wr_pin_w = reg_wr && (reg_addr == `TLIH_ADDR_PIN_CFG);
  assign wr_sense_w = reg_wr && (reg_addr == `TLIH_ADDR_SENSE);
  assign sw_set_w = wr_set_w ? reg_wdata : 16'h0000;
  assign sw_clr_w = wr_clr_w ? reg_wdata : 16'h0000;
  assign ack_mask_w = irq_ack ? tlih_mask_t'(16'h0001 << irq_src_r) : 16'h0000;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= `TLIH_RST_ENABLE;
      glb_r <= 1'b0;
      prio_r <= `TLIH_RST_PRIORITY;
      pin_cfg_r <= `TLIH_RST_PIN_CFG;
      sense_r <= `TLIH_RST_SENSE;
    end else begin
      if (wr_enable_w) en_r <= reg_wdata;
      if (wr_global_w) glb_r <= reg_wdata[0];
      if (wr_prio_w) prio_r <= reg_wdata;
      if (wr_pin_w) pin_cfg_r <= reg_wdata[7:0];
      if (wr_sense_w) sense_r <= reg_wdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal pending flags: event and software set beat any clear
  assign pend_int_nxt = ((pend_int_r & ~(sw_clr_w | (ack_mask_w & AUTO_CLR_MASK)))
                         | src_event | sw_set_w) & ~EXT_MASK;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_int_r <= 16'h0000;
    end else begin
      pend_int_r <= pend_int_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external inputs; the pin mux is ahead of the synchroniser
  generate
    for (genvar g = 0; g < 2; g++) begin : g_ext
      localparam int IDX = (g == 0) ? `TLIH_EXT_A_IDX : `TLIH_EXT_B_IDX;
      logic [`TLIH_PIN_SEL_W-1:0] sel_w;
      assign sel_w = pin_cfg_r[g*`TLIH_CFG_STRIDE +: `TLIH_PIN_SEL_W];
      tlih_ext_irq u_ext (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_raw(port_pins[sel_w]),
        .polarity(pin_cfg_r[g*`TLIH_CFG_STRIDE + `TLIH_CFG_POL_BIT]),
        .sense(sense_r[g]),
        .vec_clr(ack_mask_w[IDX]),
        .sw_set(sw_set_w[IDX]),
        .sw_clr(sw_clr_w[IDX]),
        .pending(ext_pend_w[g])
      );
    end
  endgenerate

  always_comb begin
    pend_w = pend_int_r;
    pend_w[`TLIH_EXT_A_IDX] = ext_pend_w[0];
    pend_w[`TLIH_EXT_B_IDX] = ext_pend_w[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority resolve, every cycle
  assign eligible_w = pend_w & en_r & {16{glb_r}};
  assign hi_cand_w = eligible_w & prio_r;
  assign lo_cand_w = eligible_w & ~prio_r;
  assign hi_pick_w = lowest_set(hi_cand_w);
  assign lo_pick_w = lowest_set(lo_cand_w);
  assign hi_ok_w = hi_pick_w[4] && !hi_act_r;
  assign lo_ok_w = lo_pick_w[4] && !hi_act_r && !lo_act_r;
  // ack drops the request at once; hold keeps one instruction after return
  assign req_ok_w = (hi_ok_w || lo_ok_w) && !hold_r && !irq_ack;
  assign src_nxt_w = hi_ok_w ? hi_pick_w[3:0] : lo_pick_w[3:0];
  assign vec_nxt_w = `TLIH_VEC_BASE + tlih_word_t'({src_nxt_w, 3'b000});
  assign hold_nxt = return_from_interrupt_done ? 1'b1 : (instr_done ? 1'b0 : hold_r);
  assign level_w = hi_act_r ? TLIH_HIGH : (lo_act_r ? TLIH_LOW : TLIH_IDLE);

  // request stays registered one cycle, so a standing one survives a global clear once
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req_r <= 1'b0;
      irq_high_r <= 1'b0;
      irq_src_r <= 4'h0;
      irq_vector_r <= `TLIH_VEC_BASE;
    end else begin
      irq_req_r <= req_ok_w;
      irq_high_r <= hi_ok_w;
      irq_src_r <= src_nxt_w;
      irq_vector_r <= vec_nxt_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // in-service levels; the core keeps the return address itself
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_act_r <= 1'b0;
      hi_act_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
      if (irq_ack && irq_req_r) begin
        if (irq_high_r) hi_act_r <= 1'b1;
        else lo_act_r <= 1'b1;
      end else if (return_from_interrupt_done) begin
        if (hi_act_r) hi_act_r <= 1'b0;
        else lo_act_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped reads answer zero
  always_comb begin
    if (reg_addr == `TLIH_ADDR_ENABLE) begin
      rdata_nxt = en_r;
    end else if (reg_addr == `TLIH_ADDR_GLOBAL) begin
      rdata_nxt = {15'h0000, glb_r};
    end else if (reg_addr == `TLIH_ADDR_PRIORITY) begin
      rdata_nxt = prio_r;
    end else if (reg_addr == `TLIH_ADDR_PEND_SET || reg_addr == `TLIH_ADDR_PEND_CLR) begin
      rdata_nxt = pend_w;
    end else if (reg_addr == `TLIH_ADDR_PIN_CFG) begin
      rdata_nxt = {8'h00, pin_cfg_r};
    end else if (reg_addr == `TLIH_ADDR_SENSE) begin
      rdata_nxt = {14'h0000, sense_r};
    end else if (reg_addr == `TLIH_ADDR_STATUS) begin
      rdata_nxt = {8'h00, irq_src_r, hold_r, irq_req_r, hi_act_r, lo_act_r};
    end else begin
      rdata_nxt = 16'h0000;
    end
    if (!reg_rd) rdata_nxt = 16'h0000;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq_req = irq_req_r;
  assign irq_high = irq_high_r;
  assign irq_src = irq_src_r;
  assign irq_vector = irq_vector_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_return_from_interrupt_seen;
    return_from_interrupt_done ##1 hold_r;
  endsequence

  sequence s_quiet_after;
    !irq_req_r [*1];
  endsequence

  a_req_global: assert property (irq_req_r |-> $past(glb_r))
    else $error("request raised with global enable off");
  a_req_enabled: assert property (irq_req_r |-> ($past(eligible_w) & (16'h0001 << irq_src_r)) != 16'h0000)
    else $error("request for a source not pending and enabled");
  a_vector_map: assert property (irq_req_r |-> irq_vector_r == `TLIH_VEC_BASE + {8'h00, irq_src_r, 3'b000})
    else $error("vector address does not match source");
  a_high_no_preempt: assert property (irq_req_r |-> $past(level_w) != TLIH_HIGH)
    else $error("request while a high routine is in service");
  a_return_from_interrupt_hold: assert property (s_return_from_interrupt_seen |=> s_quiet_after)
    else $error("request within the instruction after return");
  a_detect_cycle: assert property (req_ok_w |-> ##`TLIH_DETECT_CYCLES irq_req_r)
    else $error("request not raised one cycle after detection");
  a_level_wins: assert property (irq_req_r && $past(hi_cand_w != 16'h0000 && !hi_act_r && !hold_r) |-> irq_high_r)
    else $error("low level won over a high request");
  a_order_wins: assert property (irq_req_r && irq_high_r |-> irq_src_r == $past(hi_pick_w[3:0]))
    else $error("fixed order not respected");
  a_ack_drops: assert property (irq_ack |=> !irq_req_r)
    else $error("request stands after the call was taken");
  a_event_sets: assert property (|(src_event & ~EXT_MASK) |=> (pend_int_r & $past(src_event & ~EXT_MASK)) == $past(src_event & ~EXT_MASK))
    else $error("event did not set its pending flag");
  a_sw_sets: assert property (wr_set_w |=> (pend_int_r & $past(reg_wdata & ~EXT_MASK)) == $past(reg_wdata & ~EXT_MASK))
    else $error("software set did not set pending flag");
  a_repeat_req: assert property (hold_r && instr_done && !return_from_interrupt_done ##1 hi_ok_w && !irq_ack |=> irq_req_r)
    else $error("no new request after return with flag still set");

endmodule // tlih_top

// ==== tlih_regs.svh ====
// register offsets, field positions, reset values and timing counts of the interrupt handler
// assumes: included by bare name from the package and the bench
`ifndef TLIH_REGS_SVH
`define TLIH_REGS_SVH

`define TLIH_ADDR_ENABLE 8'h00
`define TLIH_ADDR_GLOBAL 8'h01
`define TLIH_ADDR_PRIORITY 8'h02
`define TLIH_ADDR_PEND_SET 8'h03
`define TLIH_ADDR_PEND_CLR 8'h04
`define TLIH_ADDR_PIN_CFG 8'h05
`define TLIH_ADDR_SENSE 8'h06
`define TLIH_ADDR_STATUS 8'h07

`define TLIH_RST_ENABLE 16'h0000
`define TLIH_RST_PRIORITY 16'h0000
`define TLIH_RST_PIN_CFG 8'h00
`define TLIH_RST_SENSE 2'h0

`define TLIH_PIN_SEL_W 3
`define TLIH_CFG_STRIDE 4
`define TLIH_CFG_POL_BIT 3

`define TLIH_EXT_A_IDX 0
`define TLIH_EXT_B_IDX 2

`define TLIH_VEC_BASE 16'h0003
`define TLIH_VEC_SHIFT 3

`define TLIH_DETECT_CYCLES 1

`endif

// ==== tlih_pkg.sv ====
// types shared by the interrupt handler modules
// assumes: nothing beyond the constants header
`include "tlih_regs.svh"

package tlih_pkg;
  typedef logic [15:0] tlih_mask_t;
  typedef logic [3:0] tlih_src_t;
  typedef logic [15:0] tlih_word_t;
  typedef enum logic [1:0] {
    TLIH_IDLE,
    TLIH_LOW,
    TLIH_HIGH
  } tlih_level_e;
endpackage

// ==== tlih_ext_irq.sv ====
// one external interrupt input: pin synchroniser, polarity, edge or level pending flag
// assumes: pin_raw is asynchronous; all other inputs are on sys_clk
module tlih_ext_irq
  import tlih_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin_raw,
  input wire logic polarity,
  input wire logic sense,
  input wire logic vec_clr,
  input wire logic sw_set,
  input wire logic sw_clr,
  output logic pending
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic pend_r;
  logic pend_nxt;
  logic active_w;
  logic rise_w;

  ////////////////////////////////////////////////////////////////////////////
  // the pin is only sampled, never driven, so crossbar users keep it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  assign active_w = (sync2_r == polarity);
  assign rise_w = active_w && !prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // edge mode: set beats any clear in the same cycle
  always_comb begin
    if (!sense) begin
      pend_nxt = active_w;
    end else if (rise_w || sw_set) begin
      pend_nxt = 1'b1;
    end else if (vec_clr || sw_clr) begin
      pend_nxt = 1'b0;
    end else begin
      pend_nxt = pend_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      prev_r <= active_w;
      pend_r <= pend_nxt;
    end
  end

  assign pending = pend_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_level_track: assert property (!sense |=> pend_r == $past(active_w))
    else $error("level mode flag does not follow the input");
  a_edge_clear: assert property (sense && vec_clr && !rise_w && !sw_set |=> !pend_r)
    else $error("edge flag not cleared on vectoring");
  a_edge_set: assert property (sense && rise_w |=> pend_r)
    else $error("active edge did not set the flag");

endmodule // tlih_ext_irq

// ==== tlih_core_model.sv ====
// core sequencer model: instruction steps, long call acknowledge, return from routine
// assumes: one instruction completes every four cycles; bench asks for acks and returns
module tlih_core_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic irq_req,
  input wire logic ack_en,
  input wire logic return_from_interrupt_go,
  output logic irq_ack,
  output logic instr_done,
  output logic return_from_interrupt_done
);
  logic [1:0] step_r;
  logic return_from_interrupt_pend_r;
  logic return_from_interrupt_now;
  // a return takes the place of an instruction completion, never both in one cycle
  assign return_from_interrupt_now = (step_r == 2'h3) && (return_from_interrupt_pend_r || return_from_interrupt_go);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_r <= 2'h0;
      return_from_interrupt_pend_r <= 1'b0;
      irq_ack <= 1'b0;
      instr_done <= 1'b0;
      return_from_interrupt_done <= 1'b0;
    end else begin
      step_r <= step_r + 2'h1;
      return_from_interrupt_pend_r <= (return_from_interrupt_pend_r || return_from_interrupt_go) && !return_from_interrupt_now;
      instr_done <= (step_r == 2'h3) && !return_from_interrupt_now;
      return_from_interrupt_done <= return_from_interrupt_now;
      // call only at an instruction boundary, once per request
      irq_ack <= irq_req && instr_done && ack_en && !irq_ack;
    end
  end
endmodule // tlih_core_model

// ==== tlih_top_bench.sv ====
// self-checking bench for the interrupt handler top
// assumes: core model gives instr_done, return_from_interrupt_done, irq_ack; bench plays software and pins
`include "tlih_regs.svh"
module tlih_top_bench
  import tlih_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] src_event;
  logic [7:0] port_pins;
  logic instr_done;
  logic irq_ack;
  logic return_from_interrupt_done;
  logic ack_en;
  logic return_from_interrupt_go;
  logic irq_req;
  logic irq_high;
  logic [3:0] irq_src;
  logic [15:0] irq_vector;
  logic [15:0] rv;
  int n_mismatch;
  int samples_checked;
  tlih_top u_tlih_top (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event), .port_pins(port_pins),
    .instr_done(instr_done), .irq_ack(irq_ack), .return_from_interrupt_done(return_from_interrupt_done), .irq_req(irq_req),
    .irq_high(irq_high), .irq_src(irq_src), .irq_vector(irq_vector));
  tlih_core_model u_tlih_core_model (.sys_clk(sys_clk), .rst_n(rst_n), .irq_req(irq_req), .ack_en(ack_en),
    .return_from_interrupt_go(return_from_interrupt_go), .irq_ack(irq_ack), .instr_done(instr_done), .return_from_interrupt_done(return_from_interrupt_done));
////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic pins(input logic [7:0] p);
    @(posedge sys_clk);
    port_pins <= p;
  endtask
  task automatic wait_req(input logic [3:0] s);
    for (int i = 0; i < 20; i++) begin
      tick(1);
      if (irq_req === 1'b1) break;
    end
    chk(16'(irq_req), 16'h0001);
    chk(16'(irq_src), 16'(s));
    chk(irq_vector, 16'h0003 + 16'h0008 * 16'(s));
  endtask
  task automatic take();
    @(posedge sys_clk);
    ack_en <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      tick(1);
      if (irq_ack === 1'b1) break;
    end
    @(posedge sys_clk);
    ack_en <= 1'b0;
    #1;
    chk(16'(irq_req), 16'h0000);
  endtask
  // request must stay down from the return until one more instruction ends
  task automatic return_from_interrupt_hold();
    @(posedge sys_clk);
    return_from_interrupt_go <= 1'b1;
    @(posedge sys_clk);
    return_from_interrupt_go <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      #1;
      if (return_from_interrupt_done === 1'b1) break;
      @(posedge sys_clk);
    end
    for (int i = 0; i < 8; i++) begin
      tick(1);
      chk(16'(irq_req), 16'h0000);
      if (instr_done === 1'b1) break;
    end
  endtask
////////////////////////////////////////
  task automatic t_reset();
    chk(16'(irq_req), 16'h0000);
    chk(irq_vector, 16'h0003);
    rd(`TLIH_ADDR_ENABLE);
    chk(rv, `TLIH_RST_ENABLE);
    rd(`TLIH_ADDR_PRIORITY);
    chk(rv, `TLIH_RST_PRIORITY);
    rd(`TLIH_ADDR_PIN_CFG);
    chk(rv, 16'(`TLIH_RST_PIN_CFG));
    rd(8'hFF);
    chk(rv, 16'h0000);
    $display("t_reset done");
  endtask
  task automatic t_basic();
    @(posedge sys_clk);
    src_event <= 16'h0020;
    @(posedge sys_clk);
    src_event <= 16'h0000;
    rd(`TLIH_ADDR_PEND_SET);
    chk(rv, 16'h0020);
    chk(16'(irq_req), 16'h0000);
    wr(`TLIH_ADDR_ENABLE, 16'hFFFF);
    tick(3);
    chk(16'(irq_req), 16'h0000);
    wr(`TLIH_ADDR_GLOBAL, 16'h0001);
    wait_req(4'h5);
    wr(`TLIH_ADDR_GLOBAL, 16'h0000);
    tick(1);
    chk(16'(irq_req), 16'h0000);
    wr(`TLIH_ADDR_GLOBAL, 16'h0000);
    wr(`TLIH_ADDR_GLOBAL, 16'h0001);
    wait_req(4'h5);
    take();
    rd(`TLIH_ADDR_STATUS);
    chk(rv & 16'h0007, 16'h0001);
    wr(`TLIH_ADDR_PEND_CLR, 16'h0020);
    return_from_interrupt_hold();
    tick(4);
    chk(16'(irq_req), 16'h0000);
    // flag left set: request returns after one instruction
    wr(`TLIH_ADDR_PEND_SET, 16'h0020);
    wait_req(4'h5);
    take();
    return_from_interrupt_hold();
    tick(1);
    chk(16'(irq_req), 16'h0000);
    wait_req(4'h5);
    take();
    wr(`TLIH_ADDR_PEND_CLR, 16'h0020);
    return_from_interrupt_hold();
    $display("t_basic done");
  endtask
  task automatic t_vec();
    for (int i = 1; i < 16; i++) begin
      if (i == 2) continue;
      wr(`TLIH_ADDR_PEND_SET, 16'h0001 << i);
      wait_req(4'(i));
      wr(`TLIH_ADDR_PEND_CLR, 16'h0001 << i);
      tick(1);
      chk(16'(irq_req), 16'h0000);
    end
    $display("t_vec done");
  endtask
  task automatic t_prio();
    wr(`TLIH_ADDR_PEND_SET, 16'h8088);
    wait_req(4'h3);
    wr(`TLIH_ADDR_PRIORITY, 16'h0080);
    wait_req(4'h7);
    chk(16'(irq_high), 16'h0001);
    take();
    wr(`TLIH_ADDR_PRIORITY, 16'h8080);
    tick(4);
    chk(16'(irq_req), 16'h0000);
    wr(`TLIH_ADDR_PEND_CLR, 16'h0080);
    return_from_interrupt_hold();
    wait_req(4'hF);
    take();
    wr(`TLIH_ADDR_PEND_CLR, 16'h8000);
    return_from_interrupt_hold();
    wait_req(4'h3);
    take();
    wr(`TLIH_ADDR_PEND_SET, 16'h0080);
    wait_req(4'h7);
    take();
    wr(`TLIH_ADDR_PEND_CLR, 16'h0088);
    return_from_interrupt_hold();
    return_from_interrupt_hold();
    tick(4);
    chk(16'(irq_req), 16'h0000);
    wr(`TLIH_ADDR_PRIORITY, 16'h0000);
    $display("t_prio done");
  endtask
  task automatic t_ext();
    pins(8'hF7);
    wr(`TLIH_ADDR_PIN_CFG, 16'h005B);
    pins(8'hFF);
    wait_req(4'h0);
    pins(8'hF7);
    tick(5);
    rd(`TLIH_ADDR_PEND_SET);
    chk(rv & 16'h0005, 16'h0000);
    wr(`TLIH_ADDR_SENSE, 16'h0001);
    pins(8'hFF);
    wait_req(4'h0);
    pins(8'hF7);
    tick(5);
    rd(`TLIH_ADDR_PEND_SET);
    chk(rv & 16'h0005, 16'h0001);
    take();
    rd(`TLIH_ADDR_PEND_SET);
    chk(rv & 16'h0005, 16'h0000);
    return_from_interrupt_hold();
    pins(8'hD7);
    wait_req(4'h2);
    pins(8'hF7);
    tick(5);
    rd(`TLIH_ADDR_PEND_SET);
    chk(rv & 16'h0005, 16'h0000);
    wr(`TLIH_ADDR_SENSE, 16'h0003);
    pins(8'hD7);
    wait_req(4'h2);
    pins(8'hF7);
    take();
    rd(`TLIH_ADDR_PEND_SET);
    chk(rv & 16'h0005, 16'h0000);
    return_from_interrupt_hold();
    $display("t_ext done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    src_event = 16'h0000;
    port_pins = 8'hFF;
    ack_en = 1'b0;
    return_from_interrupt_go = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_basic();
    t_vec();
    t_prio();
    t_ext();
    wrap_up();
  end
  initial begin
    repeat (6000) @(posedge sys_clk);
    n_mismatch++;
    $display("[ERR] %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule // tlih_top_bench
